// >>> hdl/pcd_pkg.sv
// constants, types and state layout of the configuration mechanism decoder
package pcd_pkg;

	localparam int IO_ADDR_W = 16;
	localparam logic [IO_ADDR_W-1:0] ADDR_REG_IO = 16'h0CF8;
	localparam logic [IO_ADDR_W-1:0] DATA_WIN_IO = 16'h0CFC;

	localparam logic [31:0] AREG_RESET = 32'h0000_0000;
	localparam logic [31:0] AREG_WMASK = 32'h80FF_FFFC;
	localparam logic [31:0] IGNORED_RDATA = 32'hFFFF_FFFF;
	localparam logic [3:0] BE_DWORD = 4'hF;

	localparam int EN_BIT = 31;
	localparam int BUS_HI = 23;
	localparam int BUS_LO = 16;
	localparam int DEV_HI = 15;
	localparam int DEV_LO = 11;
	localparam int FN_HI = 10;
	localparam int FN_LO = 8;
	localparam int REG_HI = 7;
	localparam int REG_LO = 2;

	localparam logic [7:0] BUS_ZERO = 8'h00;
	localparam logic [4:0] DEV_HOST_BRIDGE = 5'h00;
	localparam logic [4:0] DEV_GRAPHICS = 5'h01;
	localparam logic [2:0] FN_ZERO = 3'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT_INT = 2'b01,
		ST_WAIT_HUB = 2'b10
	} pcd_state_t;

	typedef enum logic [1:0] {
		ROUTE_INT0 = 2'b00,
		ROUTE_INT1 = 2'b01,
		ROUTE_DROP = 2'b10,
		ROUTE_HUB = 2'b11
	} pcd_route_t;

	typedef struct packed {
		pcd_state_t st;
		logic [31:0] areg;
		logic areg_rd;
		logic io_ack;
		logic [31:0] io_rdata;
		logic int_req;
		logic int_dev;
		logic [5:0] int_reg;
		logic [3:0] int_be;
		logic int_write;
		logic [31:0] int_wdata;
		logic hub_req;
		logic hub_cfg;
		logic hub_write;
		logic [31:0] hub_addr;
		logic [3:0] hub_be;
		logic [31:0] hub_wdata;
	} pcd_regs_t;

	localparam pcd_regs_t PCD_REGS_RESET = '{st: ST_IDLE, areg: AREG_RESET, default: '0};

endpackage : pcd_pkg

// >>> hdl/pcd_cfg_route.sv
// target decode of the configuration address register
module pcd_cfg_route (
	// address register contents
	input wire logic [31:0] areg,
	// decoded target
	output pcd_pkg::pcd_route_t route,
	output logic [31:0] cfg_addr
);
	import pcd_pkg::*;

	logic [7:0] bus;
	logic [4:0] dev;
	logic [2:0] fn;

	always_comb begin
		bus = areg[BUS_HI:BUS_LO];
		dev = areg[DEV_HI:DEV_LO];
		fn = areg[FN_HI:FN_LO];
		// bus number carried up, then device, function, register
		cfg_addr = {8'h00, bus, dev, fn, areg[REG_HI:REG_LO], 2'b00};
		if (bus == BUS_ZERO && (dev == DEV_HOST_BRIDGE || dev == DEV_GRAPHICS)) begin
			if (fn != FN_ZERO) begin
				route = ROUTE_DROP;
			end else if (dev == DEV_GRAPHICS) begin
				route = ROUTE_INT1;
			end else begin
				route = ROUTE_INT0;
			end
		end else begin
			route = ROUTE_HUB;
		end
	end

endmodule : pcd_cfg_route

// >>> hdl/pcd_decoder.sv
// configuration mechanism one decoder: address register, data window, steering
module pcd_decoder (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// host I/O request
	input wire logic io_req,
	input wire logic io_write,
	input wire logic [pcd_pkg::IO_ADDR_W-1:0] io_addr,
	input wire logic [3:0] io_be,
	input wire logic [31:0] io_wdata,
	// host I/O answer
	output logic io_ack,
	output logic [31:0] io_rdata,
	// internal configuration register sets
	output logic int_req,
	output logic int_dev,
	output logic [5:0] int_reg,
	output logic [3:0] int_be,
	output logic int_write,
	output logic [31:0] int_wdata,
	input wire logic int_ack,
	input wire logic [31:0] int_rdata,
	// hub interface
	output logic hub_req,
	output logic hub_cfg,
	output logic hub_write,
	output logic [31:0] hub_address_lines,
	output logic [3:0] hub_be,
	output logic [31:0] hub_wdata,
	input wire logic hub_ack,
	input wire logic [31:0] hub_rdata
);
	import pcd_pkg::*;

	pcd_regs_t s;
	pcd_regs_t n;
	pcd_route_t route;
	logic [31:0] cfg_addr;

	function automatic logic is_port(input logic [IO_ADDR_W-1:0] a,
		input logic [IO_ADDR_W-1:0] p);
		is_port = (a[IO_ADDR_W-1:2] == p[IO_ADDR_W-1:2]);
	endfunction : is_port

	pcd_cfg_route u_route (
		.areg(s.areg),
		.route(route),
		.cfg_addr(cfg_addr)
	);

	always_comb begin
		n = s;
		n.io_ack = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (io_req) begin
					n.areg_rd = 1'b0;
					if (is_port(io_addr, ADDR_REG_IO) && io_be == BE_DWORD) begin
						if (io_write) begin
							n.areg = io_wdata & AREG_WMASK;
						end else begin
							n.io_rdata = s.areg;
							n.areg_rd = 1'b1;
						end
						n.io_ack = 1'b1;
					end else if (is_port(io_addr, DATA_WIN_IO) && s.areg[EN_BIT]) begin
						case (route)
							ROUTE_INT0, ROUTE_INT1: begin
								n.int_req = 1'b1;
								n.int_dev = (route == ROUTE_INT1);
								n.int_reg = s.areg[REG_HI:REG_LO];
								n.int_be = io_be;
								n.int_write = io_write;
								n.int_wdata = io_wdata;
								n.st = ST_WAIT_INT;
							end
							ROUTE_DROP: begin
								n.io_rdata = IGNORED_RDATA;
								n.io_ack = 1'b1;
							end
							default: begin
								n.hub_req = 1'b1;
								n.hub_cfg = 1'b1;
								n.hub_addr = cfg_addr;
								n.hub_be = io_be;
								n.hub_write = io_write;
								n.hub_wdata = io_wdata;
								n.st = ST_WAIT_HUB;
							end
						endcase
					end else begin
						// plain I/O pass-through, also partial address-register hits
						n.hub_req = 1'b1;
						n.hub_cfg = 1'b0;
						n.hub_addr = {16'h0000, io_addr[IO_ADDR_W-1:2], 2'b00};
						n.hub_be = io_be;
						n.hub_write = io_write;
						n.hub_wdata = io_wdata;
						n.st = ST_WAIT_HUB;
					end
				end
			end
			ST_WAIT_INT: begin
				if (int_ack) begin
					n.int_req = 1'b0;
					n.io_rdata = int_rdata;
					n.io_ack = 1'b1;
					n.st = ST_IDLE;
				end
			end
			ST_WAIT_HUB: begin
				if (hub_ack) begin
					n.hub_req = 1'b0;
					n.io_rdata = hub_rdata;
					n.io_ack = 1'b1;
					n.st = ST_IDLE;
				end
			end
			default: begin
				n = PCD_REGS_RESET;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= PCD_REGS_RESET;
		end else if (ce) begin
			s <= n;
		end
	end

	assign io_ack = s.io_ack;
	assign io_rdata = s.io_rdata;
	assign int_req = s.int_req;
	assign int_dev = s.int_dev;
	assign int_reg = s.int_reg;
	assign int_be = s.int_be;
	assign int_write = s.int_write;
	assign int_wdata = s.int_wdata;
	assign hub_req = s.hub_req;
	assign hub_cfg = s.hub_cfg;
	assign hub_write = s.hub_write;
	assign hub_address_lines = s.hub_addr;
	assign hub_be = s.hub_be;
	assign hub_wdata = s.hub_wdata;

	// checks on the design's own outputs
	logic idle_req;
	assign idle_req = ce && s.st == ST_IDLE && io_req;

	property p_dword_write;
		@(posedge clock) disable iff (!rstn)
		(idle_req && io_write && is_port(io_addr, ADDR_REG_IO) && io_be == BE_DWORD)
		|=> (s.areg == ($past(io_wdata) & AREG_WMASK)) && s.io_ack && !s.hub_req;
	endproperty
	a_dword_write: assert property (p_dword_write)
		else $error("dword write did not load address register");

	property p_partial_passes;
		@(posedge clock) disable iff (!rstn)
		(idle_req && is_port(io_addr, ADDR_REG_IO) && io_be != BE_DWORD)
		|=> s.hub_req && !s.hub_cfg && $stable(s.areg) && !s.io_ack;
	endproperty
	a_partial_passes: assert property (p_partial_passes)
		else $error("partial address access not passed to hub");

	property p_disabled_window;
		@(posedge clock) disable iff (!rstn)
		(idle_req && is_port(io_addr, DATA_WIN_IO) && !s.areg[EN_BIT])
		|=> s.hub_req && !s.hub_cfg && !s.int_req;
	endproperty
	a_disabled_window: assert property (p_disabled_window)
		else $error("disabled window access not sent as I/O");

	property p_read_zero_bits;
		@(posedge clock) disable iff (!rstn)
		(s.io_ack && s.areg_rd) |-> s.io_rdata[30:24] == 7'h00 && s.io_rdata[1:0] == 2'b00;
	endproperty
	a_read_zero_bits: assert property (p_read_zero_bits)
		else $error("reserved address bits read non-zero");

	property p_internal_target;
		@(posedge clock) disable iff (!rstn)
		s.int_req |-> s.areg[BUS_HI:BUS_LO] == BUS_ZERO
			&& s.areg[DEV_HI:DEV_LO] == {4'h0, s.int_dev}
			&& s.areg[FN_HI:FN_LO] == FN_ZERO && s.int_reg == s.areg[REG_HI:REG_LO];
	endproperty
	a_internal_target: assert property (p_internal_target)
		else $error("internal request with wrong target");

	property p_hub_cfg_target;
		@(posedge clock) disable iff (!rstn)
		(s.hub_req && s.hub_cfg) |-> s.areg[EN_BIT]
			&& (s.areg[BUS_HI:BUS_LO] != BUS_ZERO || s.areg[DEV_HI:DEV_LO] > DEV_GRAPHICS);
	endproperty
	a_hub_cfg_target: assert property (p_hub_cfg_target)
		else $error("hub configuration cycle for internal target");

	property p_hub_lines;
		@(posedge clock) disable iff (!rstn)
		(s.hub_req && s.hub_cfg) |-> s.hub_addr[15:11] == s.areg[DEV_HI:DEV_LO]
			&& s.hub_addr[10:8] == s.areg[FN_HI:FN_LO]
			&& s.hub_addr[7:2] == s.areg[REG_HI:REG_LO];
	endproperty
	a_hub_lines: assert property (p_hub_lines)
		else $error("hub address lines do not match address register");

	property p_dropped;
		@(posedge clock) disable iff (!rstn)
		(idle_req && is_port(io_addr, DATA_WIN_IO) && s.areg[EN_BIT] && route == ROUTE_DROP)
		|=> s.io_ack && s.io_rdata == IGNORED_RDATA && !s.int_req && !s.hub_req;
	endproperty
	a_dropped: assert property (p_dropped)
		else $error("non-zero function to internal device not ignored");

	property p_window_cfg;
		@(posedge clock) disable iff (!rstn)
		(idle_req && is_port(io_addr, DATA_WIN_IO) && s.areg[EN_BIT] && route != ROUTE_DROP)
		|=> (s.int_req || (s.hub_req && s.hub_cfg)) && s.int_write == $past(io_write)
			|| (s.hub_req && s.hub_cfg && s.hub_write == $past(io_write));
	endproperty
	a_window_cfg: assert property (p_window_cfg)
		else $error("enabled window access not turned into configuration cycle");

	property p_int_done;
		@(posedge clock) disable iff (!rstn)
		(ce && s.st == ST_WAIT_INT && int_ack) |=> s.io_ack && !s.int_req
			&& s.io_rdata == $past(int_rdata) && s.st == ST_IDLE;
	endproperty
	a_int_done: assert property (p_int_done)
		else $error("internal answer not returned to host");

	property p_reset_clear;
		@(posedge clock)
		!rstn |-> s.areg == AREG_RESET && !s.io_ack && !s.int_req && !s.hub_req;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("state not cleared during reset");

	property p_io_forward;
		@(posedge clock) disable iff (!rstn)
		(idle_req && !(is_port(io_addr, ADDR_REG_IO) && io_be == BE_DWORD)
			&& !(is_port(io_addr, DATA_WIN_IO) && s.areg[EN_BIT]))
		|=> s.hub_req && !s.hub_cfg && s.hub_be == $past(io_be)
			&& s.hub_addr[IO_ADDR_W-1:2] == $past(io_addr[IO_ADDR_W-1:2]);
	endproperty
	a_io_forward: assert property (p_io_forward)
		else $error("plain I/O access forwarded wrongly");

	property p_hub_bus;
		@(posedge clock) disable iff (!rstn)
		(s.hub_req && s.hub_cfg) |-> s.hub_addr[BUS_HI:BUS_LO] == s.areg[BUS_HI:BUS_LO]
			&& s.hub_addr[31:24] == 8'h00 && s.hub_addr[1:0] == 2'b00;
	endproperty
	a_hub_bus: assert property (p_hub_bus)
		else $error("hub configuration cycle carries wrong bus number");

	property p_hub_done;
		@(posedge clock) disable iff (!rstn)
		(ce && s.st == ST_WAIT_HUB && hub_ack) |=> s.io_ack && !s.hub_req
			&& s.io_rdata == $past(hub_rdata) && s.st == ST_IDLE;
	endproperty
	a_hub_done: assert property (p_hub_done)
		else $error("hub answer not returned to host");

	property p_enable_gate;
		@(posedge clock) disable iff (!rstn)
		!s.areg[EN_BIT] |-> !s.int_req && !(s.hub_req && s.hub_cfg);
	endproperty
	a_enable_gate: assert property (p_enable_gate)
		else $error("configuration cycle while access disabled");

	property p_window_data;
		@(posedge clock) disable iff (!rstn)
		(idle_req && is_port(io_addr, DATA_WIN_IO) && s.areg[EN_BIT] && route != ROUTE_DROP)
		|=> (s.int_req && s.int_wdata == $past(io_wdata) && s.int_be == $past(io_be))
			|| (s.hub_req && s.hub_wdata == $past(io_wdata) && s.hub_be == $past(io_be));
	endproperty
	a_window_data: assert property (p_window_data)
		else $error("window data or byte enables not carried to target");

	property p_internal_confined;
		@(posedge clock) disable iff (!rstn)
		s.int_req |-> !s.hub_req;
	endproperty
	a_internal_confined: assert property (p_internal_confined)
		else $error("internal access also sent over the hub");

endmodule : pcd_decoder

// >>> verif/pcd_partner.sv
// far-side model: internal register sets and hub agent answering after a lag
module pcd_partner (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// answer timing and data
	input wire logic [1:0] lag,
	input wire logic [31:0] data,
	// internal sets
	input wire logic int_req,
	output logic int_ack,
	output logic [31:0] int_rdata,
	// hub agent
	input wire logic hub_req,
	output logic hub_ack,
	output logic [31:0] hub_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt;
	logic ack;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt <= 2'h0;
			ack <= 1'b0;
		end else begin
			ack <= 1'b0;
			cnt <= 2'h0;
			if ((int_req | hub_req) && !ack) begin
				if (cnt == lag) begin
					ack <= 1'b1;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
		end
	end
	// data only valid with the ack, inverted otherwise
	assign int_ack = ack & int_req;
	assign hub_ack = ack & hub_req;
	assign int_rdata = int_ack ? data : ~data;
	assign hub_rdata = hub_ack ? data : ~data;
endmodule : pcd_partner

// >>> verif/test_pcd_decoder.sv
// self-checking bench of the configuration mechanism decoder
module test_pcd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rstn, ce, io_req, io_write, io_ack, int_req, int_dev, int_write, int_ack;
	logic hub_req, hub_cfg, hub_write, hub_ack;
	logic [15:0] io_addr;
	logic [3:0] io_be, int_be, hub_be;
	logic [5:0] int_reg;
	logic [1:0] lag;
	logic [31:0] io_wdata, io_rdata, int_wdata, int_rdata, hub_address_lines, hub_wdata;
	logic [31:0] hub_rdata, data, areg, seed, r, v;
	int miscompares, comparisons, cycles;

	pcd_decoder dut (.clock, .rstn, .ce, .io_req, .io_write, .io_addr, .io_be,
		.io_wdata, .io_ack, .io_rdata, .int_req, .int_dev, .int_reg, .int_be, .int_write,
		.int_wdata, .int_ack, .int_rdata, .hub_req, .hub_cfg, .hub_write, .hub_address_lines,
		.hub_be, .hub_wdata, .hub_ack, .hub_rdata);
	pcd_partner far (.clock, .rstn, .lag, .data, .int_req, .int_ack, .int_rdata, .hub_req,
		.hub_ack, .hub_rdata);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task end_of_test();
		if (miscompares == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [71:0] g, input logic [71:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask : chk

	// one host access, expectations from the model register areg
	task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		int k;
		logic drop;
		logic [31:0] ar, er;
		logic [71:0] ev;
		ar = areg;
		drop = 1'b0;
		data = rnd();
		lag = 2'(rnd());
		er = data;
		ev = {2'b01, 1'b0, w, be, 16'h0, a[15:2], 2'h0, wd};
		if (a[15:2] == 14'h033E && be == 4'hF) begin
			drop = 1'b1;
			ev = '1;
			if (w) areg = wd & 32'h80FFFFFC;
			er = areg;
		end else if (a[15:2] == 14'h033F && ar[31]) begin
			ev = {2'b01, 1'b1, w, be, 8'h00, ar[23:2], 2'h0, wd};
			if (ar[23:12] == 12'h000) begin
				ev = {2'b10, ar[11], w, be, 26'h0, ar[7:2], wd};
				if (ar[10:8] != 3'h0) begin
					drop = 1'b1;
					ev = '1;
					er = 32'hFFFFFFFF;
				end
			end
		end
		@(negedge clock);
		io_req = 1'b1;
		io_write = w;
		io_addr = a;
		io_be = be;
		io_wdata = wd;
		k = 0;
		do begin
			@(negedge clock);
			k++;
			if (int_req | hub_req) chk(hub_req ? {int_req, hub_req, hub_cfg, hub_write, hub_be,
				hub_address_lines, hub_wdata} : {int_req, hub_req, int_dev, int_write, int_be,
				26'h0, int_reg, int_wdata}, ev);
		end while (io_ack !== 1'b1 && k < 40);
		io_req = 1'b0;
		chk(72'(io_ack), 72'h1);
		if (drop) chk(72'(k), 72'h1);
		if (!w) chk(72'(io_rdata), 72'(er));
	endtask : acc

	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		seed = 32'h9F925083;
		miscompares = 0;
		comparisons = 0;
		cycles = 0;
		rstn = 1'b0;
		ce = 1'b1;
		io_req = 1'b0;
		io_write = 1'b0;
		io_addr = 16'h0;
		io_be = 4'h0;
		io_wdata = 32'h0;
		data = 32'h0;
		lag = 2'h0;
		areg = 32'h0;
		repeat (5) @(negedge clock);
		rstn = 1'b1;
		acc(1'b0, 16'h0CF8, 4'hF, 32'h0);
		acc(1'b1, 16'h0CFC, 4'hF, 32'h1234);
		acc(1'b1, 16'h0CF8, 4'hF, 32'hFFFFFFFF);
		acc(1'b0, 16'h0CF8, 4'hF, 32'h0);
		acc(1'b1, 16'h0CF8, 4'h3, 32'h0);
		acc(1'b0, 16'h0CFA, 4'hC, 32'h0);
		for (int i = 0; i < 400; i++) begin
			r = rnd();
			v = rnd();
			if (r[0]) v[23:16] = 8'h00;
			if (r[1]) v[15:12] = 4'h0;
			if (r[2]) v[10:8] = 3'h0;
			case (r[5:4])
				2'h0: acc(1'b1, 16'h0CF8, 4'hF, v);
				2'h1: acc(r[3], 16'h0CFC, r[11:8] | 4'h1, v);
				2'h2: acc(r[3], 16'h0CF8, {1'b0, r[11:9]} | 4'h1, v);
				default: acc(r[3], r[31:16], r[11:8] | 4'h1, v);
			endcase
		end
		acc(1'b1, 16'h0CF8, 4'hF, 32'h80000800);
		@(negedge clock);
		rstn = 1'b0;
		areg = 32'h0;
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		acc(1'b0, 16'h0CF8, 4'hF, 32'h0);
		acc(1'b0, 16'h0CFC, 4'hF, 32'h0);
		@(negedge clock);
		ce = 1'b0;
		io_req = 1'b1;
		io_write = 1'b1;
		io_addr = 16'h0CF8;
		io_be = 4'hF;
		io_wdata = 32'h80000004;
		repeat (3) @(negedge clock);
		chk(72'({io_ack, int_req, hub_req}), 72'h0);
		io_req = 1'b0;
		ce = 1'b1;
		acc(1'b0, 16'h0CF8, 4'hF, 32'h0);
		end_of_test();
	end
endmodule : test_pcd_decoder
